//--- hw/acp_pkg.sv
// Shared constants and helpers for the amplifier control port
package acp_pkg;
  // Bus target address, 0011 011
  localparam logic [6:0] DEV_ADDR = 7'h1B;
  // Subaddress ranges and sizes in bytes
  localparam logic [7:0] SUB_LOW_LAST = 8'h1F;
  localparam logic [7:0] BQ_FIRST = 8'h29;
  localparam logic [7:0] BQ_LAST = 8'h3A;
  localparam logic [4:0] LEN_BYTE = 5'h01;
  localparam logic [4:0] LEN_WORD = 5'h04;
  localparam logic [4:0] LEN_BQ = 5'h14;
  localparam int REG_BITS = 160;
  localparam int WORDS_MAX = 5;
  // Coefficient layout, 3.23 right-aligned in 32 bits
  localparam int COEF_BITS = 26;
  localparam logic [31:0] COEF_MASK = 32'h03FF_FFFF;
  // Bit counting
  localparam logic [3:0] BITS_BYTE = 4'h8;
  // Byte roles inside a transfer
  localparam logic [2:0] ROLE_ADDRW = 3'h0;
  localparam logic [2:0] ROLE_SUB = 3'h1;
  localparam logic [2:0] ROLE_WDATA = 3'h2;
  localparam logic [2:0] ROLE_ADDRR = 3'h3;
  localparam logic [2:0] ROLE_RDATA = 3'h4;
  // Reset values
  localparam logic [7:0] RST_SUB = 8'h00;
  localparam logic [4:0] RST_CNT = 5'h00;
  // Bit-clock quarter periods for the host end
  localparam int CLK_PERIOD_NS = 10;
  localparam int QTR_STD_NS = 2500;
  localparam int QTR_FAST_NS = 625;
  localparam logic [8:0] QTR_STD_CYC = 9'((QTR_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] QTR_FAST_CYC = 9'((QTR_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef logic [REG_BITS-1:0] acp_reg_t;

  // Byte length of one subaddress
  function automatic logic [4:0] acp_reg_len(input logic [7:0] sub);
    if (sub <= SUB_LOW_LAST) begin
      return LEN_BYTE;
    end else if (sub >= BQ_FIRST && sub <= BQ_LAST) begin
      return LEN_BQ;
    end
    return LEN_WORD;
  endfunction
endpackage

//--- hw/acp_bus_if.sv
// Open-drain two-wire bus joining the host end and the device end
`timescale 1ns/1ps
interface acp_bus_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up
  assign scl = scl_host_oe ? scl_host_o : 1'b1;
  assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);

  modport dev (
    input scl,
    input sda,
    output sda_dev_o,
    output sda_dev_oe
  );

  modport host (
    input scl,
    input sda,
    output scl_host_o,
    output scl_host_oe,
    output sda_host_o,
    output sda_host_oe
  );
endinterface

//--- hw/acp_dev_end.sv
// Device end of the amplifier control port: bus target with register ports
//
// Summary of operation
// - Byte reads and writes at 100 and 400 kHz
// - Target only; never holds clock low
// - Answer fixed 7-bit address only
// - No limit on bytes per transfer
// - Low subaddresses take single or multiple bytes
// - Upper subaddresses move in four-byte groups, 8'h29 to 8'h3A in 20-byte groups
// - Keep sending bytes while host acknowledges
// - Unimplemented read bits return zero
// - Count bytes per subaddress, drop partials
// - Sequential write fills consecutive subaddresses
// - Only incomplete final subaddress is dropped
// - Write order; acknowledge address, subaddress, data
// - Acknowledge every received data byte
// - Read via repeated start, then send data
// - Host acknowledges all but last, then stops
// - Coefficients are signed 3.23, 26 bits
// - Coefficients right-aligned in 32 bits, top ignored
// - Works on system clock, no audio clock
`timescale 1ns/1ps
module acp_dev_end (
  // System
  input wire logic CLK_SYS,
  input wire logic RST,
  // Two-wire bus
  acp_bus_if.dev BUS,
  // Register write port
  output logic WR_STB,
  output logic [7:0] WR_SUB,
  output logic [4:0] WR_LEN,
  output acp_pkg::acp_reg_t WR_DATA,
  // Register read port
  output logic [7:0] RD_SUB,
  input wire acp_pkg::acp_reg_t RD_DATA,
  input wire logic [5:0] RD_WORD_BITS
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_SACK = 5'h04,
    ST_SEND = 5'h08,
    ST_MACK = 5'h10
  } acp_dev_st_e;

  acp_dev_st_e st_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic [3:0] bit_q;
  logic [7:0] shr_q;
  logic [2:0] role_q;
  logic rw_q;
  logic sda_oe_q;
  logic [7:0] sub_q;
  logic [4:0] cnt_q;
  logic [4:0] rd_idx_q;
  acp_pkg::acp_reg_t wbuf_q;
  logic wr_stb_q;
  logic [7:0] wr_sub_q;
  logic [4:0] wr_len_q;
  acp_pkg::acp_reg_t wr_data_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic byte_end, sub_done, rx_done, tx_load;
  logic [4:0] cur_len;
  logic [4:0] rd_sel;
  acp_pkg::acp_reg_t rd_masked;
  acp_pkg::acp_reg_t rd_shift;
  acp_pkg::acp_reg_t wr_full;
  acp_pkg::acp_reg_t wr_mask;
  logic [7:0] tx_byte;
  logic [31:0] word_mask;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= BUS.scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= BUS.sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // Byte events seen by the pointer logic
  assign byte_end = scl_fall && (st_q == ST_RECV) && (bit_q == acp_pkg::BITS_BYTE);
  assign sub_done = byte_end && (role_q == acp_pkg::ROLE_SUB);
  assign rx_done = byte_end && (role_q == acp_pkg::ROLE_WDATA);
  assign tx_load = scl_fall && ((st_q == ST_MACK) ||
                   (st_q == ST_SACK && role_q == acp_pkg::ROLE_ADDRW && rw_q));

  assign cur_len = acp_pkg::acp_reg_len(sub_q);

  // Zero bits above the implemented width
  always_comb begin
    word_mask = 32'hFFFF_FFFF;
    if (RD_WORD_BITS < 6'h20) begin
      word_mask = 32'((33'h1 << RD_WORD_BITS) - 33'h1);
    end
    for (int w = 0; w < acp_pkg::WORDS_MAX; w++) begin
      rd_masked[32*w +: 32] = RD_DATA[32*w +: 32] & word_mask;
    end
  end

  // Pick the byte of the register, most significant first
  assign rd_sel = cur_len - rd_idx_q - 5'h01;
  assign rd_shift = rd_masked >> {rd_sel, 3'b000};
  assign tx_byte = rd_shift[7:0];

  // Assembled write word, cleared above its length
  assign wr_mask = ~(acp_pkg::acp_reg_t'(0)) >> (8'd160 - {cur_len, 3'b000});
  always_comb begin
    wr_full = {wbuf_q[151:0], shr_q} & wr_mask;
    if (cur_len == acp_pkg::LEN_BQ) begin
      for (int w = 0; w < acp_pkg::WORDS_MAX; w++) begin
        wr_full[32*w +: 32] = wr_full[32*w +: 32] & acp_pkg::COEF_MASK;
      end
    end
  end

  // Bus protocol state machine
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      shr_q <= 8'h00;
      role_q <= acp_pkg::ROLE_ADDRW;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      st_q <= ST_RECV;
      bit_q <= 4'h0;
      role_q <= acp_pkg::ROLE_ADDRW;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      st_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        ST_RECV: begin
          if (scl_rise) begin
            shr_q <= {shr_q[6:0], sda_s2_q};
            bit_q <= bit_q + 4'h1;
          end else if (byte_end) begin
            if (role_q == acp_pkg::ROLE_ADDRW && shr_q[7:1] != acp_pkg::DEV_ADDR) begin
              st_q <= ST_IDLE;
            end else begin
              st_q <= ST_SACK;
              sda_oe_q <= 1'b1;
              if (role_q == acp_pkg::ROLE_ADDRW) begin
                rw_q <= shr_q[0];
              end
            end
          end
        end
        ST_SACK: begin
          if (scl_fall) begin
            bit_q <= 4'h0;
            if (role_q == acp_pkg::ROLE_ADDRW && rw_q) begin
              st_q <= ST_SEND;
              sda_oe_q <= ~tx_byte[7];
              shr_q <= {tx_byte[6:0], 1'b0};
            end else begin
              st_q <= ST_RECV;
              sda_oe_q <= 1'b0;
              role_q <= (role_q == acp_pkg::ROLE_ADDRW) ? acp_pkg::ROLE_SUB
                                                        : acp_pkg::ROLE_WDATA;
            end
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == acp_pkg::BITS_BYTE) begin
              st_q <= ST_MACK;
              sda_oe_q <= 1'b0;
            end else begin
              sda_oe_q <= ~shr_q[7];
              shr_q <= {shr_q[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s2_q) begin
            st_q <= ST_IDLE;
          end else if (scl_fall) begin
            st_q <= ST_SEND;
            bit_q <= 4'h0;
            sda_oe_q <= ~tx_byte[7];
            shr_q <= {tx_byte[6:0], 1'b0};
          end
        end
        default: begin
          st_q <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Subaddress pointer, byte counting and write commit
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sub_q <= acp_pkg::RST_SUB;
      cnt_q <= acp_pkg::RST_CNT;
      rd_idx_q <= acp_pkg::RST_CNT;
      wbuf_q <= '0;
      wr_stb_q <= 1'b0;
      wr_sub_q <= acp_pkg::RST_SUB;
      wr_len_q <= acp_pkg::RST_CNT;
      wr_data_q <= '0;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_det || stop_det) begin
        cnt_q <= acp_pkg::RST_CNT;
        rd_idx_q <= acp_pkg::RST_CNT;
      end else if (sub_done) begin
        sub_q <= shr_q;
        cnt_q <= acp_pkg::RST_CNT;
        rd_idx_q <= acp_pkg::RST_CNT;
      end else if (rx_done) begin
        wbuf_q <= {wbuf_q[151:0], shr_q};
        // Commit when the size is reached
        if (cnt_q + 5'h01 == cur_len) begin
          wr_stb_q <= 1'b1;
          wr_sub_q <= sub_q;
          wr_len_q <= cur_len;
          wr_data_q <= wr_full;
          cnt_q <= acp_pkg::RST_CNT;
          sub_q <= sub_q + 8'h01;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end else if (tx_load) begin
        if (rd_idx_q + 5'h01 == cur_len) begin
          rd_idx_q <= acp_pkg::RST_CNT;
          sub_q <= sub_q + 8'h01;
        end else begin
          rd_idx_q <= rd_idx_q + 5'h01;
        end
      end
    end
  end

  // Only the data line is ever pulled low
  assign BUS.sda_dev_o = 1'b0;
  assign BUS.sda_dev_oe = sda_oe_q;

  // Register port outputs
  assign WR_STB = wr_stb_q;
  assign WR_SUB = wr_sub_q;
  assign WR_LEN = wr_len_q;
  assign WR_DATA = wr_data_q;
  assign RD_SUB = sub_q;

endmodule

//--- hw/acp_host_end.sv
// Host end of the amplifier control port: bus controller with command port
`timescale 1ns/1ps
module acp_host_end (
  // System
  input wire logic CLK_SYS,
  input wire logic RST,
  // Two-wire bus
  acp_bus_if.host BUS,
  // Command
  input wire logic CMD_VALID,
  input wire logic CMD_READ,
  input wire logic [7:0] CMD_SUB,
  input wire logic [7:0] CMD_LEN,
  input wire logic FAST,
  output logic CMD_READY,
  // Write data
  input wire logic [7:0] TX_DATA,
  output logic TX_TAKE,
  // Read data and status
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic ERR
);

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_START = 5'h02,
    H_BYTE = 5'h04,
    H_RSTART = 5'h08,
    H_STOP = 5'h10
  } acp_host_st_e;

  acp_host_st_e st_q;
  logic sda_s1_q, sda_s2_q;
  logic [8:0] qcnt_q;
  logic [1:0] q_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [2:0] role_q;
  logic rd_q;
  logic [7:0] sub_q;
  logic [7:0] len_q;
  logic ack_q;
  logic scl_oe_q, sda_oe_q;
  logic take_q, rxv_q, err_q;
  logic ready_q;
  logic [7:0] rx_q;
  logic tick, rx_role;

  // Data line synchroniser
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= BUS.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // Quarter-period divider for the bit clock
  assign tick = (st_q != H_IDLE) && (qcnt_q == 9'h000);
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      qcnt_q <= 9'h000;
    end else if (st_q == H_IDLE || tick) begin
      qcnt_q <= (FAST ? acp_pkg::QTR_FAST_CYC : acp_pkg::QTR_STD_CYC) - 9'h001;
    end else begin
      qcnt_q <= qcnt_q - 9'h001;
    end
  end

  assign rx_role = (role_q == acp_pkg::ROLE_RDATA);

  // Transfer sequencer
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q <= H_IDLE;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      role_q <= acp_pkg::ROLE_ADDRW;
      rd_q <= 1'b0;
      sub_q <= 8'h00;
      len_q <= 8'h00;
      ack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      take_q <= 1'b0;
      rxv_q <= 1'b0;
      err_q <= 1'b0;
      rx_q <= 8'h00;
      ready_q <= 1'b1;
    end else begin
      take_q <= 1'b0;
      rxv_q <= 1'b0;
      err_q <= 1'b0;
      if (st_q == H_IDLE) begin
        q_q <= 2'h0;
        if (CMD_VALID) begin
          st_q <= H_START;
          ready_q <= 1'b0;
          rd_q <= CMD_READ;
          sub_q <= CMD_SUB;
          len_q <= CMD_LEN;
        end
      end else if (tick) begin
        q_q <= q_q + 2'h1;
        case (st_q)
          H_START: begin
            if (q_q == 2'h1) begin
              sda_oe_q <= 1'b1;
            end else if (q_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              st_q <= H_BYTE;
              bit_q <= 4'h0;
              role_q <= acp_pkg::ROLE_ADDRW;
              sh_q <= {acp_pkg::DEV_ADDR, 1'b0};
            end
          end
          H_RSTART: begin
            if (q_q == 2'h0) begin
              sda_oe_q <= 1'b0;
            end else if (q_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else if (q_q == 2'h2) begin
              sda_oe_q <= 1'b1;
            end else begin
              scl_oe_q <= 1'b1;
              st_q <= H_BYTE;
              bit_q <= 4'h0;
              role_q <= acp_pkg::ROLE_ADDRR;
              sh_q <= {acp_pkg::DEV_ADDR, 1'b1};
            end
          end
          H_STOP: begin
            if (q_q == 2'h0) begin
              sda_oe_q <= 1'b1;
            end else if (q_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else if (q_q == 2'h2) begin
              sda_oe_q <= 1'b0;
            end else begin
              st_q <= H_IDLE;
              ready_q <= 1'b1;
            end
          end
          H_BYTE: begin
            if (q_q == 2'h0) begin
              if (bit_q != acp_pkg::BITS_BYTE) begin
                sda_oe_q <= rx_role ? 1'b0 : ~sh_q[7];
              end else begin
                // Acknowledge all but the last byte
                sda_oe_q <= rx_role && (len_q != 8'h01);
              end
            end else if (q_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else if (q_q == 2'h2) begin
              if (bit_q != acp_pkg::BITS_BYTE) begin
                if (rx_role) begin
                  sh_q <= {sh_q[6:0], sda_s2_q};
                end
              end else begin
                ack_q <= ~sda_s2_q;
              end
            end else begin
              scl_oe_q <= 1'b1;
              if (bit_q != acp_pkg::BITS_BYTE) begin
                bit_q <= bit_q + 4'h1;
                if (!rx_role) begin
                  sh_q <= {sh_q[6:0], 1'b0};
                end
              end else begin
                bit_q <= 4'h0;
                if (!rx_role && !ack_q) begin
                  err_q <= 1'b1;
                  st_q <= H_STOP;
                end else begin
                  case (role_q)
                    acp_pkg::ROLE_ADDRW: begin
                      role_q <= acp_pkg::ROLE_SUB;
                      sh_q <= sub_q;
                    end
                    acp_pkg::ROLE_SUB: begin
                      if (rd_q) begin
                        st_q <= H_RSTART;
                      end else begin
                        // Data bytes sent most significant first
                        role_q <= acp_pkg::ROLE_WDATA;
                        sh_q <= TX_DATA;
                        take_q <= 1'b1;
                      end
                    end
                    acp_pkg::ROLE_WDATA: begin
                      len_q <= len_q - 8'h01;
                      if (len_q == 8'h01) begin
                        st_q <= H_STOP;
                      end else begin
                        sh_q <= TX_DATA;
                        take_q <= 1'b1;
                      end
                    end
                    acp_pkg::ROLE_ADDRR: begin
                      role_q <= acp_pkg::ROLE_RDATA;
                    end
                    default: begin
                      rx_q <= sh_q;
                      rxv_q <= 1'b1;
                      len_q <= len_q - 8'h01;
                      if (len_q == 8'h01) begin
                        st_q <= H_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          end
          default: begin
            st_q <= H_IDLE;
            ready_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // Open-drain drives and user outputs
  assign BUS.scl_host_o = 1'b0;
  assign BUS.scl_host_oe = scl_oe_q;
  assign BUS.sda_host_o = 1'b0;
  assign BUS.sda_host_oe = sda_oe_q;
  assign CMD_READY = ready_q;
  assign TX_TAKE = take_q;
  assign RX_DATA = rx_q;
  assign RX_VALID = rxv_q;
  assign ERR = err_q;

endmodule

//--- verification/acp_bus_asserts.sv
// Bus-level checks of the device end on the shared two-wire link
`timescale 1ns/1ps
module acp_bus_asserts (
  // System
  input wire logic CLK_SYS,
  input wire logic RST,
  // Host drives
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  // Device drives
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  // Resolved wires
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [3:0] bc_q;
  logic [1:0] nb_q;
  logic [7:0] sh_q;
  logic rw_q;
  logic nack_q;
  logic rise;
  logic start;
  logic ack_due;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // Edge, start and acknowledge decode
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign ack_due = (nb_q == 2'h0) ? (sh_q[7:1] == acp_pkg::DEV_ADDR) : !rw_q;

  // Previous wire levels
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Bit and byte position in a frame
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bc_q <= 4'h0;
      nb_q <= 2'h0;
      sh_q <= 8'h00;
    end else if (start) begin
      bc_q <= 4'h0;
      nb_q <= 2'h0;
    end else if (rise && bc_q == 4'h8) begin
      bc_q <= 4'h0;
      nb_q <= (nb_q == 2'h3) ? nb_q : nb_q + 2'h1;
    end else if (rise) begin
      bc_q <= bc_q + 4'h1;
      sh_q <= {sh_q[6:0], sda};
    end
  end

  // Frame direction and host refusal of read data
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rw_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (start) begin
      nack_q <= 1'b0;
    end else if (rise && bc_q == 4'h8 && nb_q == 2'h0) begin
      rw_q <= sh_q[0];
    end else if (rise && bc_q == 4'h8 && rw_q && sda) begin
      nack_q <= 1'b1;
    end
  end

  sequence s_ack_slot;
    rise && bc_q == 4'h8;
  endsequence

  sequence s_bit8_end;
    $fell(scl) && bc_q == 4'h8 && ack_due;
  endsequence

  a_no_stretch: assert property (!scl |-> scl_host_oe && !scl_host_o)
    else $error("clock low without host pull");
  a_dev_no_start: assert property (start |-> sda_host_oe && !sda_host_o)
    else $error("start not made by host");
  a_ack_addr: assert property (s_ack_slot ##0 (nb_q == 2'h0 && ack_due)
    |-> sda_dev_oe && !sda_dev_o) else $error("own address not acknowledged");
  a_ack_wdata: assert property (s_ack_slot ##0 (nb_q != 2'h0 && !rw_q)
    |-> sda_dev_oe && !sda) else $error("write byte not acknowledged");
  a_rd_release: assert property (s_ack_slot ##0 (nb_q != 2'h0 && rw_q)
    |-> !sda_dev_oe) else $error("device drives host ack slot");
  a_hold_high: assert property (scl && scl_q |-> $stable(sda_dev_oe))
    else $error("device data moved while clock high");
  a_ack_timely: assert property (s_bit8_end |-> ##[1:6] sda_dev_oe)
    else $error("acknowledge late");
  a_ack_release: assert property ($fell(scl) && bc_q == 4'h0 && nb_q != 2'h0 && !rw_q
    |-> ##[1:6] !sda_dev_oe) else $error("acknowledge not released");
  a_nack_quiet: assert property (nack_q |-> !sda_dev_oe)
    else $error("device sends after host refusal");
endmodule

//--- verification/tb_top.sv
// Bench driving the host end against the device end over the shared bus
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  num_checks++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module tb_top;
  typedef struct packed {
    logic [7:0] sub;
    logic [4:0] len;
    acp_pkg::acp_reg_t data;
  } acp_commit_s;

  // Stimulus, observed outputs and notes
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_sub = 8'h00;
  logic [7:0] cmd_len = 8'h01;
  logic fast = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] lfsr = 8'h5E;
  logic cmd_ready;
  logic tx_take;
  logic [7:0] rx_data;
  logic rx_valid;
  logic err;
  logic wr_stb;
  logic [7:0] wr_sub;
  logic [4:0] wr_len;
  acp_pkg::acp_reg_t wr_data;
  logic [7:0] rd_sub;
  acp_pkg::acp_reg_t rd_data;
  logic [5:0] rd_word_bits;
  int num_errors = 0;
  int num_checks = 0;
  acp_commit_s exp_wr[$];
  logic [7:0] exp_rx[$];
  logic [7:0] txq[$];

  acp_bus_if bus_if_i ();
  acp_host_end acp_host_end_i (.CLK_SYS(clk_sys), .RST(rst), .BUS(bus_if_i),
    .CMD_VALID(cmd_valid), .CMD_READ(cmd_read), .CMD_SUB(cmd_sub), .CMD_LEN(cmd_len),
    .FAST(fast), .CMD_READY(cmd_ready), .TX_DATA(tx_data), .TX_TAKE(tx_take),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .ERR(err));
  acp_dev_end acp_dev_end_i (.CLK_SYS(clk_sys), .RST(rst), .BUS(bus_if_i),
    .WR_STB(wr_stb), .WR_SUB(wr_sub), .WR_LEN(wr_len), .WR_DATA(wr_data),
    .RD_SUB(rd_sub), .RD_DATA(rd_data), .RD_WORD_BITS(rd_word_bits));
  acp_bus_asserts acp_bus_asserts_i (.CLK_SYS(clk_sys), .RST(rst),
    .scl_host_o(bus_if_i.scl_host_o), .scl_host_oe(bus_if_i.scl_host_oe),
    .sda_host_o(bus_if_i.sda_host_o), .sda_host_oe(bus_if_i.sda_host_oe),
    .sda_dev_o(bus_if_i.sda_dev_o), .sda_dev_oe(bus_if_i.sda_dev_oe),
    .scl(bus_if_i.scl), .sda(bus_if_i.sda));

  // System clock
  always #5 clk_sys = ~clk_sys;

  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  function automatic logic [4:0] reg_len(input logic [7:0] sub);
    if (sub <= acp_pkg::SUB_LOW_LAST) return 5'h01;
    if (sub >= acp_pkg::BQ_FIRST && sub <= acp_pkg::BQ_LAST) return 5'h14;
    return 5'h04;
  endfunction

  function automatic acp_pkg::acp_reg_t reg_val(input logic [7:0] sub);
    if (sub <= 8'h1F) return {152'h0, sub ^ 8'hA5};
    return {128'h0, 32'hF1E2D3C4 ^ {24'h0, sub}};
  endfunction

  // Register contents and implemented width seen by the device
  assign rd_data = reg_val(rd_sub);
  assign rd_word_bits = (rd_sub == 8'h20) ? 6'h10 : 6'h20;

  task automatic print_verdict();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic xfer(input logic rd, input logic [7:0] sub, input logic [7:0] n,
                      input logic spd);
    int cyc;
    @(negedge clk_sys);
    if (!rd) begin
      tx_data <= txq.pop_front();
    end
    cmd_read <= rd;
    cmd_sub <= sub;
    cmd_len <= n;
    fast <= spd;
    cmd_valid <= 1'b1;
    @(negedge clk_sys);
    cmd_valid <= 1'b0;
    cyc = 0;
    while (cmd_ready !== 1'b1 && cyc < 60000) begin
      @(negedge clk_sys);
      cyc++;
    end
    `CHK("cmd_ready", 1'b1, cmd_ready)
  endtask

  task automatic wr(input logic [7:0] sub, input int n, input logic spd);
    logic [7:0] p;
    logic [7:0] b;
    int cnt;
    acp_commit_s c;
    p = sub;
    cnt = 0;
    c = '0;
    for (int k = 0; k < n; k++) begin
      lfsr = lfsr_next(lfsr);
      b = lfsr;
      b[7:6] = (cnt % 4 == 0) ? 2'b11 : b[7:6];
      txq.push_back(b);
      c.data = {c.data[151:0], b};
      cnt++;
      if (cnt == int'(reg_len(p))) begin
        c.sub = p;
        c.len = reg_len(p);
        for (int w = 0; w < 5; w++) begin
          if (c.len == 5'h14) c.data[w*32 +: 32] &= acp_pkg::COEF_MASK;
        end
        exp_wr.push_back(c);
        p++;
        cnt = 0;
        c = '0;
      end
    end
    xfer(1'b0, sub, n[7:0], spd);
  endtask

  task automatic rd(input logic [7:0] sub, input int n);
    logic [7:0] p;
    int cnt;
    acp_pkg::acp_reg_t v;
    p = sub;
    cnt = 0;
    for (int k = 0; k < n; k++) begin
      v = reg_val(p);
      v[31:0] = (p == 8'h20) ? (v[31:0] & 32'h0000FFFF) : v[31:0];
      exp_rx.push_back(v[(int'(reg_len(p)) - 1 - cnt) * 8 +: 8]);
      cnt++;
      if (cnt == int'(reg_len(p))) begin
        p++;
        cnt = 0;
      end
    end
    xfer(1'b1, sub, n[7:0], 1'b1);
  endtask

  // Next write byte after each take
  always @(negedge clk_sys) begin
    if (tx_take === 1'b1 && txq.size() > 0) begin
      tx_data <= txq.pop_front();
    end
  end

  // Compare each result with the oldest note
  always @(negedge clk_sys) begin
    if (wr_stb === 1'b1 && exp_wr.size() == 0) `CHK("wr_stb", 1'b0, wr_stb)
    else if (wr_stb === 1'b1) begin
      `CHK("wr_sub", exp_wr[0].sub, wr_sub)
      `CHK("wr_len", exp_wr[0].len, wr_len)
      `CHK("wr_data", exp_wr[0].data, wr_data)
      void'(exp_wr.pop_front());
    end
    if (rx_valid === 1'b1 && exp_rx.size() == 0) `CHK("rx_valid", 1'b0, rx_valid)
    else if (rx_valid === 1'b1) begin
      `CHK("rx_data", exp_rx[0], rx_data)
      void'(exp_rx.pop_front());
    end
    if (err === 1'b1) `CHK("err", 1'b0, err)
  end

  // Hang guard
  initial begin
    #1300000;
    num_errors++;
    $display("Error watchdog expected done seen hang");
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst <= 1'b0;
    repeat (5) @(negedge clk_sys);
    wr(8'h05, 1, 1'b0);
    wr(8'h1F, 8, 1'b1);
    wr(8'h29, 20, 1'b1);
    rd(8'h1F, 3);
    repeat (20) @(negedge clk_sys);
    `CHK("wr_left", 0, exp_wr.size())
    `CHK("rx_left", 0, exp_rx.size())
    print_verdict();
  end
endmodule
